// file: rtl/dps_pkg.sv
// Purpose: Shared constants and types for the serial potentiometer interface
// Assumes: SPI mode 0 link, MSB first, one tap register and one control register
// Notes:
// Operation
// - A single read spans two select-low frames; frame two's last two bytes carry the answer.
// - Third byte is 111b plus address, fourth byte returns register contents.
// - Address 00000b is wiper position, 10000b is access control.
// - Wiper register sets the tap directly and reads back its value.
// - Each device executes its held command when select rises.
// - Frame two carries N no-ops while pending reads are answered.
// - In frame two, the answer group's first byte is 111b plus address, its second byte data.
// - Instruction: three-bit opcode over five-bit address; 000, 100, 110.
// - Sample input on rising clock, shift output on falling, MSB first.
package dps_pkg;
    localparam logic [2:0] OP_NOP     = 3'h0;
    localparam logic [2:0] OP_READ    = 3'h4;
    localparam logic [2:0] OP_WRITE   = 3'h6;
    localparam logic [2:0] OP_ECHO    = 3'h7;
    localparam logic [4:0] ADDR_WIPER = 5'h00;
    localparam logic [4:0] ADDR_ACC   = 5'h10;
    localparam logic [7:0] WIPER_RST  = 8'h80;
    localparam logic [7:0] ACC_RST    = 8'h40;
    localparam logic [7:0] ACC_MASK   = 8'h42;
    localparam int         ACC_SHDN   = 6;
    localparam int         ACC_OD     = 1;
    localparam int         GROUP_BITS = 16;

    // One executed command passed across the clock boundary
    typedef struct packed {
        logic [2:0] op;
        logic [4:0] addr;
        logic [7:0] data;
    } dps_cmd_t;
endpackage

// file: rtl/dps_spi_slave.sv
// Purpose: Serial slave of a cascadable digital potentiometer
// Assumes: sck is the link clock domain; registers live on clk
// Notes: Command word is held while select is high; the clk side acts on the synchronised select rise
`timescale 1ns/1ps
module dps_spi_slave (
    // System
    input  wire logic       clk,
    input  wire logic       reset,
    // Link
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       sdi,
    output logic            sdo_o,
    output logic            sdo_oe_n,
    // Analog control
    output logic [7:0]      wiper_tap,
    output logic            shutdown_n,
    output logic            sdo_open_drain
);
    // Link domain state; bit and group counters, whole flag, answer flag and output bit reset by select high (frame signal)
    logic [15:0]       shift_q;
    logic [15:0]       rx_q;
    logic [4:0]        bitcnt_q;
    logic [1:0]        grp_q;
    logic              whole_q;
    logic [15:0]       ans_q;
    logic              ans_act_q;
    logic              out_q;
    logic              cmd_vld_q;
    dps_pkg::dps_cmd_t cmd_q;
    dps_pkg::dps_cmd_t pend_q;

    wire [15:0] shift_d = {shift_q[14:0], sdi};
    wire [4:0]  bits_d  = (bitcnt_q == 5'd15) ? 5'd0 : bitcnt_q + 5'd1;
    wire        grp_end = (bitcnt_q == 5'd15);

    // Register domain
    logic [7:0]  wiper_q;
    logic [7:0]  acc_q;
    logic [2:0]  cs_sync_q;
    // Select rise seen on clk; sync resets to idle high so no false edge follows reset
    wire         cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
    wire         cmd_evt = cs_rise & cmd_vld_q;
    dps_pkg::dps_cmd_t cmd_hold;

    function automatic logic [7:0] reg_sel(input logic [4:0] a, input logic [7:0] w, input logic [7:0] c);
        reg_sel = (a == dps_pkg::ADDR_ACC) ? c : w;
    endfunction

    // Answer word for a pending read: echo, then data
    wire [7:0] rd_data = reg_sel(pend_q.addr, wiper_q, acc_q);
    wire [15:0] ans_word = {dps_pkg::OP_ECHO, pend_q.addr, rd_data};

    // Rising edge sampling; sixteen-bit delay line and group counter
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            bitcnt_q  <= 5'd0;
            grp_q     <= 2'd0;
            whole_q   <= 1'b1;
        end
        else
        begin
            shift_q  <= shift_d;
            bitcnt_q <= bits_d;
            whole_q  <= (bits_d[2:0] == 3'd0);
            if (grp_end)
            begin
                rx_q  <= shift_d;
                grp_q <= (grp_q == 2'd3) ? 2'd3 : grp_q + 2'd1;
            end
        end
    end

    // Falling edge shifting; answer replaces delay line during second group
    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            ans_act_q <= 1'b0;
            out_q     <= 1'b0;
        end
        else
        begin
            if (bitcnt_q == 5'd0 && grp_q == 2'd1 && pend_q.op == dps_pkg::OP_READ)
            begin
                ans_act_q <= 1'b1;
                ans_q     <= {ans_word[14:0], 1'b0};
                out_q     <= ans_word[15];
            end
            else if (bitcnt_q == 5'd0 && grp_q != 2'd1)
            begin
                ans_act_q <= 1'b0;
                out_q     <= shift_q[15];
            end
            else if (ans_act_q)
            begin
                out_q <= ans_q[15];
                ans_q <= {ans_q[14:0], 1'b0};
            end
            else
            begin
                out_q <= shift_q[15];
            end
        end
    end

    // Commit at select rise; word then stands until the next rise, so no toggle is needed
    always_ff @(posedge cs_n)
    begin
        cmd_vld_q <= whole_q && grp_q != 2'd0;
        if (whole_q && grp_q != 2'd0)
        begin
            cmd_q     <= rx_q;
            if (rx_q[15:13] == dps_pkg::OP_READ)
                pend_q <= rx_q;
            else
                pend_q.op <= dps_pkg::OP_NOP;
        end
    end

    // Select synchroniser; stage one read only by stage two
    always_ff @(posedge clk)
    begin
        if (reset)
            cs_sync_q <= 3'b111;
        else
            cs_sync_q <= {cs_sync_q[1:0], cs_n};
    end

    assign cmd_hold = cmd_q;

    // Register writes; command word is stable since the select rise has crossed the synchroniser
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wiper_q <= dps_pkg::WIPER_RST;
            acc_q   <= dps_pkg::ACC_RST;
        end
        else if (cmd_evt && cmd_hold.op == dps_pkg::OP_WRITE)
        begin
            if (cmd_hold.addr == dps_pkg::ADDR_ACC)
                acc_q <= cmd_hold.data & dps_pkg::ACC_MASK;
            else if (cmd_hold.addr == dps_pkg::ADDR_WIPER || cmd_hold.addr == 5'h01)
                wiper_q <= cmd_hold.data;
        end
    end

    // Pin drive; open drain only pulls low
    assign sdo_o          = acc_q[dps_pkg::ACC_OD] ? 1'b0 : out_q;
    assign sdo_oe_n       = cs_n | (acc_q[dps_pkg::ACC_OD] & out_q);
    assign wiper_tap      = wiper_q;
    assign shutdown_n     = acc_q[dps_pkg::ACC_SHDN];
    assign sdo_open_drain = acc_q[dps_pkg::ACC_OD];

    // Checks in the register domain
    sequence cmd_arrives_s;
        cmd_evt && cmd_hold.op == dps_pkg::OP_WRITE && cmd_hold.addr == dps_pkg::ADDR_WIPER;
    endsequence

    wiper_write_a: assert property (@(posedge clk) disable iff (reset)
        cmd_arrives_s |=> wiper_q == $past(cmd_hold.data)) else $error("wiper not written");
    acc_write_a: assert property (@(posedge clk) disable iff (reset)
        cmd_evt && cmd_hold.op == dps_pkg::OP_WRITE && cmd_hold.addr == dps_pkg::ADDR_ACC
        |=> acc_q == ($past(cmd_hold.data) & dps_pkg::ACC_MASK)) else $error("control not written");
    no_cmd_hold_a: assert property (@(posedge clk) disable iff (reset)
        !cmd_evt |=> $stable(wiper_q) && $stable(acc_q)) else $error("register changed without command");
    read_no_change_a: assert property (@(posedge clk) disable iff (reset)
        cmd_evt && cmd_hold.op != dps_pkg::OP_WRITE |=> $stable(wiper_q)) else $error("non-write altered wiper");
    tap_follows_a: assert property (@(posedge clk) disable iff (reset)
        wiper_tap == wiper_q) else $error("tap output mismatch");
    acc_reserved_a: assert property (@(posedge clk) disable iff (reset)
        (acc_q & ~dps_pkg::ACC_MASK) == 8'h00) else $error("reserved control bit set");
    // Checks in the link domain
    group_count_a: assert property (@(posedge sck) disable iff (cs_n)
        bitcnt_q == 5'd15 |=> bitcnt_q == 5'd0) else $error("group count wrong");
    delay_line_a: assert property (@(posedge sck) disable iff (cs_n)
        1'b1 |=> shift_q[0] == $past(sdi)) else $error("delay line not shifting");
endmodule

// file: verif/dps_host_model.sv
// Purpose: Behavioural SPI mode 0 master for the potentiometer slave
// Assumes: link clock of 80 ns, idle low, running only inside frames
// Notes: sdo_line is the resolved wire level, sampled on each sck rise
`timescale 1ns/1ps
module dps_host_model (
    // Link
    output logic      sck,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo_line
);
    // Idle bus: deselected, clock parked low
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // One frame of nbits, MSB first; clock stands still between frames
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = '0;
        cs_n <= 1'b0;
        #40;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            sdi <= tx[i];
            #40;
            sck <= 1'b1;
            rx = {rx[30:0], sdo_line};
            #40;
            sck <= 1'b0;
        end
        #40;
        cs_n <= 1'b1;
        sdi  <= ~sdi; // Released line must not keep the last bit
        #200;
    endtask
endmodule

// file: verif/dps_spi_slave_tb.sv
// Purpose: Self-checking bench for the potentiometer serial slave
// Assumes: one device, host model as master, pull-up on the data line
// Notes: A leading NOP frame has no bench check of its own; only read_no_change_a covers it, for the wiper
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module dps_spi_slave_tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    wire logic   sck;
    wire logic   cs_n;
    wire logic   sdi;
    wire logic   sdo_line;
    logic        sdo_o;
    logic        sdo_oe_n;
    logic        shutdown_n;
    logic        sdo_open_drain;
    logic [7:0]  wiper_tap;
    logic [31:0] rx;
    logic [15:0] d16;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;

    // System clock and resolved open-drain or push-pull data wire
    always #2.5 clk = ~clk;
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo_o;

    dps_spi_slave i_dps_spi_slave (.clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .wiper_tap(wiper_tap), .shutdown_n(shutdown_n),
        .sdo_open_drain(sdo_open_drain));
    dps_host_model u_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));

    // Verdict and end of run
    task conclude;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Register write, then a read in the cascade-compatible four-byte form
    task wr(input logic [4:0] a, input logic [7:0] d);
        u_host.xfer({16'h0000, dps_pkg::OP_WRITE, a, d}, 16, rx);
    endtask
    task rd(input logic [4:0] a, output logic [15:0] ed);
        u_host.xfer({16'h0000, dps_pkg::OP_READ, a, 8'h00}, 16, rx);
        u_host.xfer({dps_pkg::OP_READ, a, 8'h00, dps_pkg::OP_NOP, 5'h00, 8'h00}, 32, rx);
        ed = rx[15:0];
    endtask

    // Hang guard, well above the few thousand cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("wiper_rst", dps_pkg::WIPER_RST, wiper_tap)
        `CHK("shdn_rst", 1'b1, shutdown_n)
        `CHK("od_rst", 1'b0, sdo_open_drain)
        u_host.xfer(32'h0000_0000, 16, rx);
        wr(dps_pkg::ADDR_WIPER, 8'h55);
        `CHK("wiper_wr", 8'h55, wiper_tap)
        rd(dps_pkg::ADDR_WIPER, d16);
        `CHK("rd_wiper", {dps_pkg::OP_ECHO, dps_pkg::ADDR_WIPER, 8'h55}, d16)
        // Two groups: first passes through, only the last one executes
        u_host.xfer({dps_pkg::OP_WRITE, dps_pkg::ADDR_WIPER, 8'h77, 16'h0000}, 32, rx);
        `CHK("pass_thru", {dps_pkg::OP_WRITE, dps_pkg::ADDR_WIPER, 8'h77}, rx[15:0])
        `CHK("last_grp", 8'h55, wiper_tap)
        // Frame with a partial byte after a whole write group is dropped, write included
        u_host.xfer(32'h000C_0123, 20, rx);
        `CHK("partial", 8'h55, wiper_tap)
        wr(dps_pkg::ADDR_ACC, 8'h02);
        `CHK("shdn_wr", 1'b0, shutdown_n)
        `CHK("od_wr", 1'b1, sdo_open_drain)
        rd(dps_pkg::ADDR_ACC, d16);
        `CHK("rd_acc_od", {dps_pkg::OP_ECHO, dps_pkg::ADDR_ACC, 8'h02}, d16)
        wr(dps_pkg::ADDR_ACC, 8'hFF);
        rd(dps_pkg::ADDR_ACC, d16);
        `CHK("rd_acc_msk", {dps_pkg::OP_ECHO, dps_pkg::ADDR_ACC, dps_pkg::ACC_MASK}, d16)
        `CHK("wiper_keep", 8'h55, wiper_tap)
        `CHK("oe_idle", 1'b1, sdo_oe_n)
        conclude();
    end
endmodule
